// File: design/usbdsc_pkg.sv
/*
 * usbdsc_pkg: register map, field positions, pids and fsm states
 * for the usb device setup-control block. No surroundings assumed.
 */
package usbdsc_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [11:0] A_CTRLA = 12'h000;
	localparam logic [11:0] A_CTRLB = 12'h004;
	localparam logic [11:0] A_DEVADDR = 12'h008;
	localparam logic [11:0] A_INTF = 12'h00c;
	localparam logic [11:0] A_FRAME = 12'h010;
	localparam logic [11:0] A_DESCB = 12'h014;
	localparam logic [11:0] A_PAD = 12'h018;
	localparam logic [11:0] A_SMRY = 12'h01c;
	localparam logic [3:0] A_EP_PAGE = 4'h1;
	// word index inside one 32-byte endpoint window
	localparam logic [2:0] O_CFG = 3'h0;
	localparam logic [2:0] O_STA = 3'h1;
	localparam logic [2:0] O_STACLR = 3'h2;
	localparam logic [2:0] O_STASET = 3'h3;
	localparam logic [2:0] O_FLAG = 3'h4;
	localparam logic [2:0] O_IEN = 3'h5;
	localparam logic [2:0] O_PCK = 3'h6;
	// field positions
	localparam int CA_SOFTRST = 0;
	localparam int CA_EN = 1;
	localparam int CA_MODE = 7;
	localparam int CB_DETACH = 0;
	localparam int CB_UPRES = 1;
	localparam int CB_SPD = 2;
	localparam int DA_EN = 7;
	localparam int IF_SOF = 0;
	localparam int IF_ENDRST = 1;
	localparam int IF_RAMUF = 2;
	localparam int ST_DTOUT = 0;
	localparam int ST_DTIN = 1;
	localparam int ST_CURBK = 2;
	localparam int ST_STALL0 = 4;
	localparam int ST_STALL1 = 5;
	localparam int ST_BK0 = 6;
	localparam int ST_BK1 = 7;
	localparam int FL_SETUP = 4;
	localparam int FR_ERR = 15;
	localparam int PCK_CNT = 16;
	// codes
	localparam logic [2:0] EPT_CTRL = 3'h1;
	localparam logic [3:0] PID_SETUP = 4'hd;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [6:0] DEF_ADDR = 7'h00;
	localparam int DESC_SHIFT = 5;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_DESC = 3'h1, ST_WPID = 3'h3,
		ST_DATA = 3'h2, ST_WR = 3'h6, ST_DONE = 3'h7
	} usbdsc_state_t;
endpackage

// File: design/usbdsc_top.sv
/*
 * usbdsc_top: device-side enable/reset control, bus reset, sof capture
 * and setup transaction handling with descriptor fetch and buffer write.
 * Assumes a packet layer that delivers decoded tokens, data pid and a
 * byte stream with crc bytes included, and a memory port with handshakes.
 */
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usbdsc_top #(
	parameter int NUM_EP = 8,
	parameter int SIZE_W = 10
) (
	input wire logic ref_clk, // 10 MHz
	input wire logic resetn, // async, active low
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [11:0] s_axi_awaddr, // write byte address
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	output logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	input wire logic [11:0] s_axi_araddr, // read byte address
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	input wire logic tok_valid, // token received, pulse
	input wire logic [3:0] tok_pid, // token pid
	input wire logic [6:0] tok_addr, // token device address
	input wire logic [3:0] tok_ep, // token endpoint
	input wire logic [10:0] tok_frame, // sof frame number
	input wire logic tok_err, // token crc or stuff error
	input wire logic pid_valid, // data pid received, pulse
	input wire logic [3:0] pid_code, // data pid
	input wire logic pid_err, // pid check error
	input wire logic rx_valid, // payload byte valid
	output logic rx_ready, // payload byte taken
	input wire logic [7:0] rx_data, // payload or crc byte
	input wire logic rx_last, // last byte of packet
	input wire logic rx_err, // packet crc or stuff error
	input wire logic bus_reset, // bus reset level
	input wire logic in_underflow, // in-stage ram underflow pulse
	output logic hs_ack, // send ack, pulse
	output logic desc_rd_valid, // descriptor read request
	input wire logic desc_rd_ready, // descriptor read done
	output logic [31:0] desc_rd_addr, // descriptor address
	input wire logic [31:0] desc_rd_data, // buffer pointer
	output logic mem_wr_valid, // buffer byte write request
	input wire logic mem_wr_ready, // buffer byte write taken
	output logic [31:0] mem_wr_addr, // buffer byte address
	output logic [7:0] mem_wr_data, // buffer byte
	output logic usb_clk_en, // module clock running
	output logic pad_suspend, // pad held in suspend
	output logic dev_attach, // pull-up connected
	output logic host_mode, // active mode is host
	output logic [1:0] speed_active, // speed taken at enable
	output logic irq // endpoint interrupt request
);
	typedef struct packed {
		usbdsc_pkg::usbdsc_state_t st;
		logic en, mode, mode_act, detach, up_res, addr_en, fnerr, rst_d;
		logic [1:0] spd, spd_act;
		logic [6:0] dev_addr;
		logic [2:0] intf;
		logic [10:0] frame_number_reg;
		logic [31:0] desc_base, pad_trim;
		logic [NUM_EP-1:0][7:0] cfg, sta, flag, ien;
		logic [NUM_EP-1:0][SIZE_W-1:0] size, bcnt;
		logic [2:0] ep;
		logic [31:0] buf_addr;
		logic [10:0] nb;
		logic wr_ok, last, err;
		logic aw_full, w_full, bvalid, rvalid;
		logic [11:0] aw_addr;
		logic [31:0] w_data, rdata;
		logic [3:0] w_strb;
		logic [1:0] bresp, rresp;
		logic ack, dr_valid, mw_valid;
		logic [31:0] dr_addr, mw_addr;
		logic [7:0] mw_data;
	} usbdsc_q_t;

	usbdsc_q_t s_reg, s_next;
	logic [NUM_EP-1:0] smry, ep_irq;
	logic dev_on, wr_do, do_soft_reset_bit;
	logic [31:0] wm, wv;

	// register window decode; missing endpoints answer as unmapped
	function automatic logic hit(input logic [11:0] a);
		hit = (a[11:5] == 7'h00) || (a[11:8] == usbdsc_pkg::A_EP_PAGE &&
			32'(a[7:5]) < NUM_EP && a[4:2] <= usbdsc_pkg::O_PCK);
	endfunction

	function automatic logic [31:0] rd(input usbdsc_q_t q, input logic [11:0] a);
		logic [2:0] e;
		e = a[7:5];
		rd = 32'h0;
		if (a == usbdsc_pkg::A_CTRLA) begin
			rd[usbdsc_pkg::CA_EN] = q.en;
			rd[usbdsc_pkg::CA_MODE] = q.mode;
		end else if (a == usbdsc_pkg::A_CTRLB) begin
			rd[usbdsc_pkg::CB_DETACH] = q.detach;
			rd[usbdsc_pkg::CB_UPRES] = q.up_res;
			rd[usbdsc_pkg::CB_SPD +: 2] = q.spd;
		end else if (a == usbdsc_pkg::A_DEVADDR) begin
			rd[7:0] = {q.addr_en, q.dev_addr};
		end else if (a == usbdsc_pkg::A_INTF) begin
			rd[2:0] = q.intf;
		end else if (a == usbdsc_pkg::A_FRAME) begin
			rd[13:3] = q.frame_number_reg;
			rd[usbdsc_pkg::FR_ERR] = q.fnerr;
		end else if (a == usbdsc_pkg::A_DESCB) begin
			rd = q.desc_base;
		end else if (a == usbdsc_pkg::A_PAD) begin
			rd = q.pad_trim;
		end else if (a == usbdsc_pkg::A_SMRY) begin
			rd[NUM_EP-1:0] = smry;
		end else if (hit(a) && a[11:8] == usbdsc_pkg::A_EP_PAGE) begin
			if (a[4:2] == usbdsc_pkg::O_CFG) begin
				rd[7:0] = q.cfg[e];
			end else if (a[4:2] == usbdsc_pkg::O_FLAG) begin
				rd[7:0] = q.flag[e];
			end else if (a[4:2] == usbdsc_pkg::O_IEN) begin
				rd[7:0] = q.ien[e];
			end else if (a[4:2] == usbdsc_pkg::O_PCK) begin
				rd[SIZE_W-1:0] = q.size[e];
				rd[usbdsc_pkg::PCK_CNT +: SIZE_W] = q.bcnt[e];
			end else begin
				rd[7:0] = q.sta[e];
			end
		end
	endfunction

	// per-endpoint summary and gated interrupt
	for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
		assign smry[i] = |s_reg.flag[i];
		assign ep_irq[i] = |(s_reg.flag[i] & s_reg.ien[i]);
	end

	// port views of state
	assign dev_on = s_reg.en && !s_reg.mode_act;
	assign usb_clk_en = s_reg.en;
	assign pad_suspend = !s_reg.en;
	assign dev_attach = dev_on && !s_reg.detach;
	assign host_mode = s_reg.en && s_reg.mode_act;
	assign speed_active = s_reg.spd_act;
	assign irq = dev_on && |ep_irq;
	assign s_axi_awready = !s_reg.aw_full;
	assign s_axi_wready = !s_reg.w_full;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign rx_ready = s_reg.st == usbdsc_pkg::ST_DATA;
	assign hs_ack = s_reg.ack;
	assign desc_rd_valid = s_reg.dr_valid;
	assign desc_rd_addr = s_reg.dr_addr;
	assign mem_wr_valid = s_reg.mw_valid;
	assign mem_wr_addr = s_reg.mw_addr;
	assign mem_wr_data = s_reg.mw_data;
	// write merge: byte enables pick new bytes over the current value
	assign wm = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
		{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
	assign wv = (rd(s_reg, s_reg.aw_addr) & ~wm) | (s_reg.w_data & wm);
	assign wr_do = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
	assign do_soft_reset_bit = wr_do && s_reg.aw_addr == usbdsc_pkg::A_CTRLA &&
		wv[usbdsc_pkg::CA_SOFTRST];

	// next state: register writes first, hardware after so that sets win; soft reset last of all
	always_comb begin
		logic [2:0] e;
		logic [2:0] te;
		logic ep_ok;
		logic fin;
		e = s_reg.aw_addr[7:5];
		te = tok_ep[2:0];
		ep_ok = 1'b0;
		fin = 1'b0;
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.rst_d = bus_reset;
		// axi channels, each taken on its own handshake
		if (s_axi_awvalid && !s_reg.aw_full) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_full) begin
			s_next.w_full = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;
		if (s_axi_arvalid && !s_reg.rvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd(s_reg, s_axi_araddr);
			s_next.rresp = hit(s_axi_araddr) ? usbdsc_pkg::RESP_OK : usbdsc_pkg::RESP_SLVERR;
		end
		// register writes once both address and data are held
		if (wr_do) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = hit(s_reg.aw_addr) ? usbdsc_pkg::RESP_OK : usbdsc_pkg::RESP_SLVERR;
			if (s_reg.aw_addr == usbdsc_pkg::A_CTRLA) begin
				s_next.en = wv[usbdsc_pkg::CA_EN];
				s_next.mode = wv[usbdsc_pkg::CA_MODE];
				if (wv[usbdsc_pkg::CA_EN] && !s_reg.en) begin
					s_next.mode_act = wv[usbdsc_pkg::CA_MODE];
					s_next.spd_act = s_reg.spd;
				end
			end else if (s_reg.aw_addr == usbdsc_pkg::A_CTRLB) begin
				s_next.detach = wv[usbdsc_pkg::CB_DETACH];
				s_next.up_res = wv[usbdsc_pkg::CB_UPRES];
				s_next.spd = wv[usbdsc_pkg::CB_SPD +: 2];
			end else if (s_reg.aw_addr == usbdsc_pkg::A_DEVADDR) begin
				{s_next.addr_en, s_next.dev_addr} = wv[7:0];
			end else if (s_reg.aw_addr == usbdsc_pkg::A_INTF) begin
				s_next.intf = s_reg.intf & ~(s_reg.w_data[2:0] & wm[2:0]);
			end else if (s_reg.aw_addr == usbdsc_pkg::A_DESCB) begin
				s_next.desc_base = wv;
			end else if (s_reg.aw_addr == usbdsc_pkg::A_PAD) begin
				s_next.pad_trim = wv;
			end else if (hit(s_reg.aw_addr) && s_reg.aw_addr[11:8] == usbdsc_pkg::A_EP_PAGE) begin
				if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_CFG) begin
					s_next.cfg[e] = wv[7:0];
					// both directions off: endpoint disabled
					if (wv[2:0] == 3'h0 && wv[6:4] == 3'h0) begin
						s_next.ien[e] = 8'h00;
						s_next.flag[e] = 8'h00;
						s_next.sta[e][usbdsc_pkg::ST_STALL0] = 1'b0;
						s_next.sta[e][usbdsc_pkg::ST_STALL1] = 1'b0;
					end
				end else if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_STACLR) begin
					s_next.sta[e] = s_reg.sta[e] & ~(s_reg.w_data[7:0] & wm[7:0]);
				end else if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_STASET) begin
					s_next.sta[e] = s_reg.sta[e] | (s_reg.w_data[7:0] & wm[7:0]);
				end else if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_FLAG) begin
					s_next.flag[e] = s_reg.flag[e] & ~(s_reg.w_data[7:0] & wm[7:0]);
				end else if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_IEN) begin
					s_next.ien[e] = wv[7:0];
				end else if (s_reg.aw_addr[4:2] == usbdsc_pkg::O_PCK) begin
					s_next.size[e] = wv[SIZE_W-1:0];
				end
			end
		end
		// sof capture and ram underflow
		if (dev_on && tok_valid && tok_pid == usbdsc_pkg::PID_SOF) begin
			s_next.frame_number_reg = tok_frame;
			s_next.fnerr = tok_err;
			s_next.intf[usbdsc_pkg::IF_SOF] = 1'b1;
		end
		if (dev_on && in_underflow)
			s_next.intf[usbdsc_pkg::IF_RAMUF] = 1'b1;
		// setup transaction
		case (s_reg.st)
		usbdsc_pkg::ST_IDLE: begin
			if (tok_valid && tok_pid == usbdsc_pkg::PID_SETUP && !tok_err) begin
				ep_ok = 32'(tok_ep) < NUM_EP && s_reg.cfg[te] != 8'h00;
				// address zero until software enables its own
				if (tok_addr == (s_reg.addr_en ? s_reg.dev_addr : usbdsc_pkg::DEF_ADDR)
					&& ep_ok
					&& s_reg.cfg[te][2:0] == usbdsc_pkg::EPT_CTRL) begin
					s_next.ep = te;
					s_next.dr_valid = 1'b1;
					s_next.dr_addr = s_reg.desc_base + (32'(te) << usbdsc_pkg::DESC_SHIFT);
					s_next.st = usbdsc_pkg::ST_DESC;
				end
			end
		end
		usbdsc_pkg::ST_DESC: begin
			if (desc_rd_ready) begin
				s_next.dr_valid = 1'b0;
				s_next.buf_addr = desc_rd_data;
				s_next.st = usbdsc_pkg::ST_WPID;
			end
		end
		usbdsc_pkg::ST_WPID: begin
			if (pid_valid) begin
				s_next.nb = 11'h000;
				s_next.wr_ok = !s_reg.flag[s_reg.ep][usbdsc_pkg::FL_SETUP];
				s_next.st = (!pid_err && pid_code == usbdsc_pkg::PID_DATA0) ?
					usbdsc_pkg::ST_DATA : usbdsc_pkg::ST_IDLE;
			end
		end
		usbdsc_pkg::ST_DATA: begin
			if (rx_valid) begin
				s_next.nb = s_reg.nb + 11'h001;
				s_next.last = rx_last;
				s_next.err = rx_err;
				// crc bytes land only while room is left
				if (s_reg.wr_ok && s_reg.nb < 11'(s_reg.size[s_reg.ep])) begin
					s_next.mw_valid = 1'b1;
					s_next.mw_addr = s_reg.buf_addr + 32'(s_reg.nb);
					s_next.mw_data = rx_data;
					s_next.st = usbdsc_pkg::ST_WR;
				end else begin
					fin = rx_last;
				end
			end
		end
		usbdsc_pkg::ST_WR: begin
			if (mem_wr_ready) begin
				s_next.mw_valid = 1'b0;
				s_next.st = usbdsc_pkg::ST_DATA;
				fin = s_reg.last;
			end
		end
		usbdsc_pkg::ST_DONE: begin
			s_next.ack = 1'b1;
			s_next.bcnt[s_reg.ep] = (s_reg.nb >= 11'h002) ?
				SIZE_W'(s_reg.nb - 11'h002) : '0;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_DTOUT] = 1'b1;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_DTIN] = 1'b1;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_CURBK] = 1'b1;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_BK0] = 1'b1;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_BK1] = 1'b0;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_STALL0] = 1'b0;
			s_next.sta[s_reg.ep][usbdsc_pkg::ST_STALL1] = 1'b0;
			s_next.flag[s_reg.ep][usbdsc_pkg::FL_SETUP] = 1'b1;
			s_next.st = usbdsc_pkg::ST_IDLE;
		end
		default: s_next.st = usbdsc_pkg::ST_IDLE;
		endcase
		// packet end: errors abort silently, clean ones finish
		if (fin)
			s_next.st = (s_next.err || (s_reg.st == usbdsc_pkg::ST_DATA && rx_err)) ?
				usbdsc_pkg::ST_IDLE : usbdsc_pkg::ST_DONE;
		// bus reset overrides the updates above on the device side, except cfg of endpoint 0; soft reset still wins
		if (dev_on && bus_reset) begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (i != 0)
					s_next.cfg[i] = 8'h00;
				s_next.ien[i] = 8'h00;
				s_next.flag[i] = 8'h00;
				s_next.sta[i][usbdsc_pkg::ST_STALL0] = 1'b0;
				s_next.sta[i][usbdsc_pkg::ST_STALL1] = 1'b0;
			end
			s_next.frame_number_reg = 11'h000;
			s_next.dev_addr = 7'h00;
			s_next.addr_en = 1'b0;
			s_next.up_res = 1'b0;
		end
		if (dev_on && s_reg.rst_d && !bus_reset)
			s_next.intf[usbdsc_pkg::IF_ENDRST] = 1'b1;
		// disabled or reset link: abandon any transfer in flight
		if (!dev_on || bus_reset) begin
			s_next.st = usbdsc_pkg::ST_IDLE;
			s_next.dr_valid = 1'b0;
			s_next.mw_valid = 1'b0;
			s_next.ack = 1'b0;
		end
		// soft reset keeps only the pending write answer
		if (do_soft_reset_bit) begin
			s_next = '0;
			s_next.bvalid = 1'b1;
		end
	end

	// one state register; everything resets to zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	off_quiet_a: assert property (!usb_clk_en |-> pad_suspend && !dev_attach && !hs_ack)
		else $error("disabled controller not quiet");
	enable_bit_a: assert property (wr_do && s_reg.aw_addr == usbdsc_pkg::A_CTRLA && !do_soft_reset_bit
		|=> usb_clk_en == $past(wv[usbdsc_pkg::CA_EN]))
		else $error("enable bit not followed");
	soft_reset_a: assert property (do_soft_reset_bit |=> !usb_clk_en ##1 !usb_clk_en [*2])
		else $error("soft reset did not disable");
	mode_take_a: assert property ($rose(usb_clk_en) |-> host_mode == s_reg.mode)
		else $error("mode not taken at enable");
	addr_clear_a: assert property (dev_on && bus_reset |=> !s_reg.addr_en && s_reg.frame_number_reg == 11'h0)
		else $error("bus reset left address enabled");
	end_reset_a: assert property (dev_on && $fell(bus_reset) |=> s_reg.intf[usbdsc_pkg::IF_ENDRST])
		else $error("end of reset flag missing");
	sof_latch_a: assert property (dev_on && tok_valid && tok_pid == usbdsc_pkg::PID_SOF && !bus_reset
		|=> s_reg.frame_number_reg == $past(tok_frame) && s_reg.intf[usbdsc_pkg::IF_SOF])
		else $error("sof frame not latched");
	bad_addr_a: assert property (s_reg.st == usbdsc_pkg::ST_IDLE && tok_valid
		&& tok_pid == usbdsc_pkg::PID_SETUP && tok_addr != (s_reg.addr_en ? s_reg.dev_addr : 7'h0)
		|=> s_reg.st == usbdsc_pkg::ST_IDLE && !desc_rd_valid)
		else $error("foreign setup not dropped");
	pid_check_a: assert property (s_reg.st == usbdsc_pkg::ST_WPID && pid_valid
		&& (pid_err || pid_code != usbdsc_pkg::PID_DATA0) |=> s_reg.st == usbdsc_pkg::ST_IDLE)
		else $error("bad data pid accepted");
	room_left_a: assert property (mem_wr_valid |-> (mem_wr_addr - s_reg.buf_addr)
		< 32'(s_reg.size[s_reg.ep]))
		else $error("byte stored past packet size");
	ack_update_a: assert property (hs_ack |-> s_reg.flag[s_reg.ep][usbdsc_pkg::FL_SETUP]
		&& s_reg.sta[s_reg.ep][usbdsc_pkg::ST_BK0] && !s_reg.sta[s_reg.ep][usbdsc_pkg::ST_BK1])
		else $error("setup status not updated with ack");
	setup_done_c: cover property (hs_ack ##1 irq);
	sof_seen_c: cover property (tok_valid && tok_pid == usbdsc_pkg::PID_SOF && dev_on);
	reset_end_c: cover property (dev_on && $fell(bus_reset));
	crc_drop_c: cover property (s_reg.st == usbdsc_pkg::ST_DATA && rx_valid && rx_last && rx_err);
endmodule

// File: verif/test_usbdsc_top.sv
/* test_usbdsc_top: register, setup, sof and reset tests of usbdsc_top.
 * assumes usbdsc_host as usb partner; bench answers memory requests. */
`timescale 1ns/1ps
module test_usbdsc_top;
	logic ref_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready = 0, bus_reset = 0, in_underflow = 0, hs_ack, rx_ready;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, desc_rd_addr, mem_wr_addr, v;
	logic [3:0] s_axi_wstrb = 4'hf, tok_pid, tok_ep, pid_code;
	logic [1:0] s_axi_bresp, s_axi_rresp, speed_active;
	logic tok_valid, tok_err, pid_valid, pid_err, rx_valid, rx_last, rx_err, irq;
	logic [6:0] tok_addr;
	logic [10:0] tok_frame;
	logic [7:0] rx_data, mem_wr_data;
	logic desc_rd_valid, desc_rd_ready = 0, mem_wr_valid, mem_wr_ready = 0;
	logic usb_clk_en, pad_suspend, dev_attach, host_mode;
	logic [31:0] desc_rd_data = 32'h2000;
	int error_cnt = 0, num_checks = 0, acks, wrs, descs;
	int tn[4] = '{5, 7, 8, 10}, tw[4] = '{7, 8, 8, 8};
	usbdsc_top uut (.*);
	usbdsc_host h (.*);
	always #50 ref_clk = ~ref_clk;
	// memory answers each request after one wait cycle; events counted
	always @(posedge ref_clk) begin
		desc_rd_ready <= desc_rd_valid && !desc_rd_ready;
		mem_wr_ready <= mem_wr_valid && !mem_wr_ready;
		acks += hs_ack;
		wrs += mem_wr_valid && mem_wr_ready;
		descs += desc_rd_valid && desc_rd_ready;
	end
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// axi4-lite write: each channel released once taken, bready up until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// axi4-lite read, masked compare
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk);
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata & m;
		s_axi_rready <= 1'b0;
		chk(v, e);
	endtask
	function automatic logic [11:0] ep(input logic [2:0] o);
		return {usbdsc_pkg::A_EP_PAGE, 3'h0, o, 2'h0};
	endfunction
	// setup token then data packet; counters restarted off the edge
	task automatic su(input logic [6:0] a, input int n, input logic [3:0] p, input logic e);
		@(negedge ref_clk);
		{acks, wrs, descs} = '0;
		h.tok(usbdsc_pkg::PID_SETUP, a, 11'h0, 1'b0);
		repeat (4) @(posedge ref_clk);
		h.pkt(p, n, e);
		repeat (6) @(posedge ref_clk);
	endtask
	// expected counts packed as descriptor reads, acks, buffer writes
	task automatic bad(input logic [6:0] a, input logic [3:0] p, input logic e, input int x);
		su(a, 4, p, e);
		chk(32'(descs * 256 + acks * 16 + wrs), 32'(x));
	endtask
	initial begin
		#2000000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		chk({usb_clk_en, pad_suspend, dev_attach}, 3'b010);
		wr(12'h018, 32'h5);
		wr(12'h004, 32'h8);
		chk(32'(speed_active), 0);
		wr(12'h000, 32'h2);
		chk({usb_clk_en, pad_suspend, host_mode, speed_active, dev_attach}, 6'h25);
		wr(12'h004, 32'h9);
		chk(32'(dev_attach), 0);
		wr(12'h004, 32'h8);
		rc(12'h0f0, 0, 0);
		chk(32'(s_axi_rresp), 32'(usbdsc_pkg::RESP_SLVERR));
		wr(12'h0f0, 32'h1);
		chk(32'(s_axi_bresp), 32'(usbdsc_pkg::RESP_SLVERR));
		wr(12'h008, 32'h85);
		wr(12'h014, 32'h1000);
		wr(ep(0), 32'h1);
		wr(ep(6), 32'h8);
		wr(ep(5), 32'h10);
		// payload lengths around the packet size
		for (int k = 0; k < 4; k++) begin
			wr(ep(4), 32'h10);
			wr(ep(3), 32'hb0);
			su(7'h05, tn[k], usbdsc_pkg::PID_DATA0, 1'b0);
			chk(32'(acks), 1);
			chk(32'(wrs), 32'(tw[k]));
			chk(mem_wr_addr, 32'h2000 + 32'(tw[k]) - 1);
			chk(32'(mem_wr_data), 32'h9f + 32'(tw[k]));
			rc(ep(6), 32'(tn[k]) << 16, 32'h3ff0000);
			rc(ep(1), 32'h47, 32'hff);
			rc(ep(4), 32'h10, 32'h10);
			chk(32'(irq), 1);
		end
		chk(desc_rd_addr, 32'h1000);
		su(7'h05, 4, usbdsc_pkg::PID_DATA0, 1'b0);
		chk(32'(acks * 16 + wrs), 16);
		wr(ep(4), 32'h10);
		bad(7'h06, usbdsc_pkg::PID_DATA0, 1'b0, 'h000);
		bad(7'h05, 4'hb, 1'b0, 'h100);
		// crc error shows only at the end: bytes already stored, no ack
		bad(7'h05, usbdsc_pkg::PID_DATA0, 1'b1, 'h106);
		wr(ep(0), 32'h2);
		bad(7'h05, usbdsc_pkg::PID_DATA0, 1'b0, 'h000);
		wr(ep(3), 32'h30);
		wr(ep(0), 32'h0);
		bad(7'h05, usbdsc_pkg::PID_DATA0, 1'b0, 'h000);
		rc(ep(5), 0, 32'hff);
		rc(ep(1), 0, 32'h30);
		h.tok(usbdsc_pkg::PID_SOF, 7'h0, 11'h123, 1'b1);
		rc(12'h010, 32'h8918, 32'hffff);
		in_underflow <= 1'b1;
		@(posedge ref_clk);
		in_underflow <= 1'b0;
		rc(12'h00c, 32'h5, 32'h5);
		wr(ep(0), 32'h1);
		wr(ep(3), 32'h30);
		wr(ep(5), 32'h10);
		wr(12'h004, 32'ha);
		bus_reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bus_reset <= 1'b0;
		rc(12'h008, 0, 32'hff);
		rc(12'h010, 0, 32'h3ff8);
		rc(ep(0), 1, 32'hff);
		rc(ep(1), 0, 32'h30);
		rc(ep(5), 0, 32'hff);
		rc(12'h004, 32'h8, 32'hf);
		rc(12'h00c, 32'h2, 32'h2);
		bad(7'h05, usbdsc_pkg::PID_DATA0, 1'b0, 'h000);
		// host talks at default address zero until one is assigned
		bad(7'h00, usbdsc_pkg::PID_DATA0, 1'b0, 'h116);
		wr(12'h000, 32'h1);
		rc(12'h014, 0, 32'hffffffff);
		chk({usb_clk_en, pad_suspend}, 2'b01);
		wr(12'h000, 32'h82);
		chk({host_mode, dev_attach, usb_clk_en}, 3'b101);
		wr(12'h000, 32'h80);
		chk({usb_clk_en, pad_suspend, host_mode}, 3'b010);
		report_and_stop();
	end
endmodule

// File: verif/usbdsc_host.sv
/* usbdsc_host: usb host model sending tokens, data pids and payload bytes.
 * assumes the bench clock and the setup block's packet-layer ports. */
`timescale 1ns/1ps
module usbdsc_host (
	input wire logic ref_clk, // shared clock
	output logic tok_valid, // token pulse
	output logic [3:0] tok_pid, // token pid
	output logic [6:0] tok_addr, // device address
	output logic [3:0] tok_ep, // endpoint
	output logic [10:0] tok_frame, // sof frame
	output logic tok_err, // token error
	output logic pid_valid, // data pid pulse
	output logic [3:0] pid_code, // data pid
	output logic pid_err, // pid error
	output logic rx_valid, // byte valid
	input wire logic rx_ready, // byte taken
	output logic [7:0] rx_data, // byte
	output logic rx_last, // last byte
	output logic rx_err // crc or stuff error
);
	// lines start idle: strobes and packet lines low, token fields all ones
	initial begin
		{tok_valid, pid_valid, rx_valid, pid_err} = '0;
		{tok_pid, tok_addr, tok_ep, tok_frame, tok_err} = '1;
		{pid_code, rx_data, rx_last, rx_err} = '0;
	end
	// one-cycle token, address and frame fields scrambled afterwards
	task automatic tok(input logic [3:0] p, input logic [6:0] a, input logic [10:0] f,
		input logic e);
		@(posedge ref_clk);
		{tok_valid, tok_pid, tok_addr, tok_ep, tok_frame, tok_err} <= {1'b1, p, a, 4'h0, f, e};
		@(posedge ref_clk);
		tok_valid <= 1'b0;
		{tok_addr, tok_frame} <= ~{a, f};
	endtask
	// data pid, n payload bytes, two crc bytes; a deaf device is not waited on forever
	task automatic pkt(input logic [3:0] p, input int n, input logic e);
		@(posedge ref_clk);
		{pid_valid, pid_code} <= {1'b1, p};
		@(posedge ref_clk);
		pid_valid <= 1'b0;
		for (int i = 0; i < n + 2; i++) begin
			rx_valid <= 1'b1;
			rx_data <= 8'ha0 + 8'(i);
			{rx_last, rx_err} <= {i == n + 1, e && i == n + 1};
			@(posedge ref_clk);
			for (int w = 0; w < 8 && !rx_ready; w++) @(posedge ref_clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
endmodule
